// ==== src/tcoc_top.sv ====
// 8-bit timer/counter with two output compare units behind a classic Wishbone slave
// Operation
// - Counter and both compare registers are eight bits wide.
// - All timer interrupt flags live in one flag register, each masked separately.
// - Timer tick comes from prescaler or external count pin, chosen by clock select.
// - Clock select zero stops the counter: no timer tick.
// - Count 0x00 is BOTTOM, 0xFF is MAX, both flagged internally.
// - TOP is 0xFF or compare register A, depending on mode.
// - Each timer tick clears, increments or decrements the counter as mode needs.
// - Software reads and writes the counter at any time, tick or not.
// - A counter write beats a simultaneous count or clear.
// - Three wave mode bits pick the sequence: two in control A, one in B.
// - Overflow flag set where the mode says; it can request an interrupt.
// - Counter compared continuously with both compare registers; equality is a match.
// - Compare flag sets on the timer tick after the match, not during it.
// - Enabled set compare flag requests interrupt; servicing clears it automatically.
// - Writing one to a compare flag bit clears that flag.
// - Each compare output formed from its match, wave mode and output mode field.
// - MAX and BOTTOM indicators handle extreme-value cases in the modes needing them.
// - Compare registers double buffered in PWM modes, direct in normal and CTC.
// - Buffered compare value moves to active register only on the timer tick at TOP.
// - Software reaches the buffer when buffering, else the active register directly.
// - Non-PWM force strobe acts like a match on output only; no flag, no clear.
// - Any counter write blocks every match in the next timer cycle, even stopped.
// - Reset clears both internal compare output states to zero.
// - Mode zero counts up only, wraps 0xFF to 0x00, overflow as count becomes zero.
// - Mode two clears the counter on match with compare A, which sets TOP.
// - Fast PWM TOP is 0xFF in mode three, compare A in mode seven.
`include "tcoc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tcoc_top
  import tcoc_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [`TCOC_ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // External count pin, asynchronous
  input wire logic EXTERNAL_COUNT_PIN,
  // Interrupt requests and service acknowledges
  output logic [2:0] IRQ_REQ,
  input wire logic [2:0] IRQ_SERVICED,
  // Compare outputs and their output enables
  output logic COMPARE_OUTPUT_A,
  output logic COMPARE_OUTPUT_B,
  output logic COMPARE_OUTPUT_A_EN,
  output logic COMPARE_OUTPUT_B_EN
);

  tcoc_ctrl_a_s timer_control_a;
  tcoc_ctrl_b_s timer_control_b;
  tcoc_wave_e wave_mode_field;
  tcoc_irq_s timer_flag_register;
  tcoc_irq_s timer_mask_register;
  logic [7:0] count_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] buffer_a;
  logic [7:0] buffer_b;
  logic count_down;
  logic block_pending;
  logic [`TCOC_PRE_W-1:0] prescale;
  logic ext_meta, ext_sync, ext_prev;
  logic timer_tick;
  logic wb_req, wb_wr, wb_byte0;
  logic wr_ctrl_b, wr_count, wr_flags;
  logic is_pwm, is_fast, is_phase, at_bottom, at_max, at_top;
  logic match_a, match_b, force_a, force_b;
  logic [7:0] top_val;
  logic [7:0] next_count;
  logic next_down;
  logic [31:0] next_rdata;
  logic compare_output_a_state, compare_output_b_state;

  // Output action of one unit; returns new state
  function automatic logic wave_out(input logic cur, input logic [1:0] com, input logic pwm,
                                    input logic fast, input logic hit, input logic frc,
                                    input logic bottom, input logic down, input logic is_a,
                                    input logic fast_cmpa);
    logic res;
    res = cur;
    if (!pwm) begin
      if (hit || frc) begin
        case (com)
          2'b01: res = ~cur;
          2'b10: res = 1'b0;
          2'b11: res = 1'b1;
          default: res = cur;
        endcase
      end
    end else if (fast) begin
      if (com == 2'b01 && is_a && fast_cmpa && hit) begin
        res = ~cur;
      end else if (com[1]) begin
        if (hit) begin
          res = com[0];
        end else if (bottom) begin
          res = ~com[0];
        end
      end
    end else begin
      if (com[1] && hit) begin
        res = down ? ~com[0] : com[0];
      end
    end
    return res;
  endfunction

  assign wave_mode_field = tcoc_wave_e'({timer_control_b.wave_mode_bit2, timer_control_a.wave_lo});

  // Mode decode
  always_comb begin
    is_fast = (wave_mode_field == TCOC_WAVE_FAST_MAX) || (wave_mode_field == TCOC_WAVE_FAST_CMPA);
    is_phase = (wave_mode_field == TCOC_WAVE_PC_MAX) || (wave_mode_field == TCOC_WAVE_PC_CMPA);
    is_pwm = is_fast || is_phase;
    if (wave_mode_field == TCOC_WAVE_CTC || wave_mode_field == TCOC_WAVE_PC_CMPA ||
        wave_mode_field == TCOC_WAVE_FAST_CMPA) begin
      top_val = compare_value_a;
    end else begin
      top_val = `TCOC_MAX;
    end
    at_bottom = (count_value == `TCOC_BOTTOM);
    at_max = (count_value == `TCOC_MAX);
    at_top = (count_value == top_val);
  end

  // Matches are suppressed for one timer cycle after a counter write
  assign match_a = (count_value == compare_value_a) && !block_pending;
  assign match_b = (count_value == compare_value_b) && !block_pending;

  // Wishbone decode; writes land on the edge where ack is seen high
  assign wb_req = WB_CYC_I && WB_STB_I;
  assign wb_wr = wb_req && WB_WE_I && WB_ACK_O;
  assign wb_byte0 = WB_SEL_I[0];
  assign wr_ctrl_b = wb_wr && wb_byte0 && (WB_ADR_I == `TCOC_OFF_CTRL_B);
  assign wr_count = wb_wr && wb_byte0 && (WB_ADR_I == `TCOC_OFF_COUNT);
  assign wr_flags = wb_wr && wb_byte0 && (WB_ADR_I == `TCOC_OFF_FLAGS);
  assign force_a = wr_ctrl_b && WB_DAT_I[`TCOC_CTRLB_FORCE_A] && !is_pwm;
  assign force_b = wr_ctrl_b && WB_DAT_I[`TCOC_CTRLB_FORCE_B] && !is_pwm;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req && !WB_ACK_O;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (WB_ADR_I == `TCOC_OFF_CTRL_A) begin
      next_rdata[7:0] = {timer_control_a.com_a, timer_control_a.com_b, 2'b00, timer_control_a.wave_lo};
    end else if (WB_ADR_I == `TCOC_OFF_CTRL_B) begin
      next_rdata[3:0] = timer_control_b;
    end else if (WB_ADR_I == `TCOC_OFF_COUNT) begin
      next_rdata[7:0] = count_value;
    end else if (WB_ADR_I == `TCOC_OFF_CMP_A) begin
      next_rdata[7:0] = is_pwm ? buffer_a : compare_value_a;
    end else if (WB_ADR_I == `TCOC_OFF_CMP_B) begin
      next_rdata[7:0] = is_pwm ? buffer_b : compare_value_b;
    end else if (WB_ADR_I == `TCOC_OFF_MASK) begin
      next_rdata[2:0] = timer_mask_register;
    end else if (WB_ADR_I == `TCOC_OFF_FLAGS) begin
      next_rdata[2:0] = timer_flag_register;
    end else if (WB_ADR_I == `TCOC_OFF_STATUS) begin
      next_rdata[4:0] = {at_max, at_bottom, count_down, compare_output_b_state, compare_output_a_state};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (wb_req && !WB_ACK_O) begin
      WB_DAT_O <= next_rdata;
    end
  end

  // Control and mask registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      timer_control_a <= '0;
      timer_control_b <= '0;
      timer_mask_register <= '0;
    end else if (wb_wr && wb_byte0) begin
      if (WB_ADR_I == `TCOC_OFF_CTRL_A) begin
        timer_control_a <= {WB_DAT_I[`TCOC_CTRLA_COMA_LO +: 2], WB_DAT_I[`TCOC_CTRLA_COMB_LO +: 2],
                            WB_DAT_I[`TCOC_CTRLA_WGM_LO +: 2]};
      end else if (WB_ADR_I == `TCOC_OFF_CTRL_B) begin
        timer_control_b <= {WB_DAT_I[`TCOC_CTRLB_WGM2], tcoc_cs_e'(WB_DAT_I[`TCOC_CTRLB_CS_LO +: 3])};
      end else if (WB_ADR_I == `TCOC_OFF_MASK) begin
        timer_mask_register <= WB_DAT_I[2:0];
      end
    end
  end

  // External pin synchroniser plus edge history
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= EXTERNAL_COUNT_PIN;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Free-running prescaler
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + `TCOC_PRE_W'(1);
    end
  end

  // Tick select; stop gives no tick at all
  always_comb begin
    case (timer_control_b.clock_select_field)
      TCOC_CS_DIV1: timer_tick = 1'b1;
      TCOC_CS_DIV8: timer_tick = (prescale & `TCOC_DIV8) == `TCOC_DIV8;
      TCOC_CS_DIV64: timer_tick = (prescale & `TCOC_DIV64) == `TCOC_DIV64;
      TCOC_CS_DIV256: timer_tick = (prescale & `TCOC_DIV256) == `TCOC_DIV256;
      TCOC_CS_DIV1024: timer_tick = prescale == `TCOC_DIV1024;
      TCOC_CS_EXT_FALL: timer_tick = ext_prev && !ext_sync;
      TCOC_CS_EXT_RISE: timer_tick = !ext_prev && ext_sync;
      default: timer_tick = 1'b0;
    endcase
  end

  // Counting sequence per mode
  always_comb begin
    next_count = count_value + 8'h01;
    next_down = 1'b0;
    if (wave_mode_field == TCOC_WAVE_CTC) begin
      if (match_a) begin
        next_count = `TCOC_BOTTOM;
      end
    end else if (is_fast) begin
      if (at_top) begin
        next_count = `TCOC_BOTTOM;
      end
    end else if (is_phase) begin
      next_down = count_down;
      if (count_down && at_bottom) begin
        next_down = 1'b0;
      end else if (!count_down && at_top) begin
        next_down = 1'b1;
      end
      next_count = next_down ? count_value - 8'h01 : count_value + 8'h01;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      count_value <= `TCOC_RST_BYTE;
      count_down <= 1'b0;
    end else if (wr_count) begin
      count_value <= WB_DAT_I[7:0];
    end else if (timer_tick) begin
      count_value <= next_count;
      count_down <= next_down;
    end
  end

  // Blocking window lasts until the next timer tick
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      block_pending <= 1'b0;
    end else if (wr_count) begin
      block_pending <= 1'b1;
    end else if (timer_tick) begin
      block_pending <= 1'b0;
    end
  end

  // Compare registers; buffers update at TOP in PWM modes
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      compare_value_a <= `TCOC_RST_BYTE;
      compare_value_b <= `TCOC_RST_BYTE;
      buffer_a <= `TCOC_RST_BYTE;
      buffer_b <= `TCOC_RST_BYTE;
    end else begin
      if (wb_wr && wb_byte0 && WB_ADR_I == `TCOC_OFF_CMP_A) begin
        buffer_a <= WB_DAT_I[7:0];
      end
      if (wb_wr && wb_byte0 && WB_ADR_I == `TCOC_OFF_CMP_B) begin
        buffer_b <= WB_DAT_I[7:0];
      end
      if (!is_pwm) begin
        if (wb_wr && wb_byte0 && WB_ADR_I == `TCOC_OFF_CMP_A) begin
          compare_value_a <= WB_DAT_I[7:0];
        end
        if (wb_wr && wb_byte0 && WB_ADR_I == `TCOC_OFF_CMP_B) begin
          compare_value_b <= WB_DAT_I[7:0];
        end
      end else if (timer_tick && !wr_count && !count_down && at_top) begin
        // Fast PWM wraps to BOTTOM here, phase-correct turns at TOP
        compare_value_a <= buffer_a;
        compare_value_b <= buffer_b;
      end
    end
  end

  // Flags: hardware set wins over software or service clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      timer_flag_register <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_flags && WB_DAT_I[i]) begin
          timer_flag_register[i] <= 1'b0;
        end else if (IRQ_SERVICED[i]) begin
          timer_flag_register[i] <= 1'b0;
        end
      end
      if (timer_tick) begin
        if (match_a) begin
          timer_flag_register.cmp_a <= 1'b1;
        end
        if (match_b) begin
          timer_flag_register.cmp_b <= 1'b1;
        end
        if (is_fast ? (at_top && !wr_count) : is_phase ? (at_bottom && count_down) : at_max) begin
          timer_flag_register.ovf <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      IRQ_REQ <= 3'b000;
    end else begin
      IRQ_REQ <= timer_flag_register & timer_mask_register;
    end
  end

  // Compare output states; matches act on the tick, forces at once
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      compare_output_a_state <= 1'b0;
      compare_output_b_state <= 1'b0;
    end else begin
      compare_output_a_state <= wave_out(compare_output_a_state, timer_control_a.com_a, is_pwm, is_fast,
                                         timer_tick && match_a, force_a, timer_tick && at_bottom,
                                         count_down, 1'b1,
                                         wave_mode_field == TCOC_WAVE_FAST_CMPA);
      compare_output_b_state <= wave_out(compare_output_b_state, timer_control_a.com_b, is_pwm, is_fast,
                                         timer_tick && match_b, force_b, timer_tick && at_bottom,
                                         count_down, 1'b0, 1'b0);
    end
  end

  // Pin drive copies; enable follows a non-zero output mode
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      COMPARE_OUTPUT_A <= 1'b0;
      COMPARE_OUTPUT_B <= 1'b0;
      COMPARE_OUTPUT_A_EN <= 1'b0;
      COMPARE_OUTPUT_B_EN <= 1'b0;
    end else begin
      COMPARE_OUTPUT_A <= compare_output_a_state;
      COMPARE_OUTPUT_B <= compare_output_b_state;
      COMPARE_OUTPUT_A_EN <= |timer_control_a.com_a;
      COMPARE_OUTPUT_B_EN <= |timer_control_a.com_b;
    end
  end

endmodule // tcoc_top

`default_nettype wire

// ==== src/tcoc_map.svh ====
// Register offsets, field positions, reset values and prescaler masks of the timer block
`ifndef TCOC_MAP_SVH
`define TCOC_MAP_SVH
`define TCOC_ADDR_W 5
`define TCOC_OFF_CTRL_A 5'h00
`define TCOC_OFF_CTRL_B 5'h04
`define TCOC_OFF_COUNT 5'h08
`define TCOC_OFF_CMP_A 5'h0C
`define TCOC_OFF_CMP_B 5'h10
`define TCOC_OFF_MASK 5'h14
`define TCOC_OFF_FLAGS 5'h18
`define TCOC_OFF_STATUS 5'h1C
`define TCOC_BOTTOM 8'h00
`define TCOC_MAX 8'hFF
`define TCOC_RST_BYTE 8'h00
`define TCOC_BIT_OVF 0
`define TCOC_BIT_CMPA 1
`define TCOC_BIT_CMPB 2
`define TCOC_CTRLA_WGM_LO 0
`define TCOC_CTRLA_COMB_LO 4
`define TCOC_CTRLA_COMA_LO 6
`define TCOC_CTRLB_CS_LO 0
`define TCOC_CTRLB_WGM2 3
`define TCOC_CTRLB_FORCE_B 6
`define TCOC_CTRLB_FORCE_A 7
`define TCOC_PRE_W 10
`define TCOC_DIV8 10'h0007
`define TCOC_DIV64 10'h003F
`define TCOC_DIV256 10'h00FF
`define TCOC_DIV1024 10'h03FF
`endif

// ==== src/tcoc_pkg.sv ====
// Types shared by the timer block
package tcoc_pkg;
  typedef enum logic [2:0] {
    TCOC_WAVE_NORMAL = 3'b000,
    TCOC_WAVE_PC_MAX = 3'b001,
    TCOC_WAVE_CTC = 3'b010,
    TCOC_WAVE_FAST_MAX = 3'b011,
    TCOC_WAVE_RSVD4 = 3'b100,
    TCOC_WAVE_PC_CMPA = 3'b101,
    TCOC_WAVE_RSVD6 = 3'b110,
    TCOC_WAVE_FAST_CMPA = 3'b111
  } tcoc_wave_e;
  typedef enum logic [2:0] {
    TCOC_CS_STOP = 3'b000,
    TCOC_CS_DIV1 = 3'b001,
    TCOC_CS_DIV8 = 3'b010,
    TCOC_CS_DIV64 = 3'b011,
    TCOC_CS_DIV256 = 3'b100,
    TCOC_CS_DIV1024 = 3'b101,
    TCOC_CS_EXT_FALL = 3'b110,
    TCOC_CS_EXT_RISE = 3'b111
  } tcoc_cs_e;
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] wave_lo;
  } tcoc_ctrl_a_s;
  typedef struct packed {
    logic wave_mode_bit2;
    tcoc_cs_e clock_select_field;
  } tcoc_ctrl_b_s;
  typedef struct packed {
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tcoc_irq_s;
endpackage : tcoc_pkg

// ==== bench/tcoc_checker.sv ====
// Port-level assertions for the timer block
`include "tcoc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tcoc_checker
  import tcoc_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [`TCOC_ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Timer outputs
  input wire logic [2:0] IRQ_REQ,
  input wire logic COMPARE_OUTPUT_A,
  input wire logic COMPARE_OUTPUT_B,
  input wire logic COMPARE_OUTPUT_A_EN,
  input wire logic COMPARE_OUTPUT_B_EN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_wr(a);
    WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && WB_ACK_O && WB_ADR_I == a;
  endsequence

  a_ack_answer: assert property (s_req |=> WB_ACK_O)
    else $error("ack did not follow request");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000)
    else $error("read data above eight bits");
  a_enable_a: assert property (s_wr(`TCOC_OFF_CTRL_A) |->
    ##2 COMPARE_OUTPUT_A_EN == ($past(WB_DAT_I[7:6], 2) != 2'b00))
    else $error("output enable A wrong");
  a_enable_b: assert property (s_wr(`TCOC_OFF_CTRL_A) |->
    ##2 COMPARE_OUTPUT_B_EN == ($past(WB_DAT_I[5:4], 2) != 2'b00))
    else $error("output enable B wrong");
  a_mask_gates: assert property (s_wr(`TCOC_OFF_MASK) ##0 WB_DAT_I[2:0] == 3'b000 |->
    ##2 (IRQ_REQ == 3'b000) [*3])
    else $error("masked request still raised");
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=>
    IRQ_REQ == 3'b000 && !COMPARE_OUTPUT_A && !COMPARE_OUTPUT_B && !WB_ACK_O)
    else $error("outputs not cleared by reset");
endmodule // tcoc_checker

`default_nettype wire

// ==== bench/tb_tcoc_top.sv ====
// Self-checking bench for the timer block
`include "tcoc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_tcoc_top
  import tcoc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n, cyc, stb, we, pin, ack, oa, ob, oa_en, ob_en;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o;
  logic [2:0] irq, svc;
  logic [7:0] q;
  int errors, comparisons;

  tcoc_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .EXTERNAL_COUNT_PIN(pin), .IRQ_REQ(irq), .IRQ_SERVICED(svc), .COMPARE_OUTPUT_A(oa),
    .COMPARE_OUTPUT_B(ob), .COMPARE_OUTPUT_A_EN(oa_en), .COMPARE_OUTPUT_B_EN(ob_en));

  always #2 clk = ~clk;

  task automatic wrap_up;
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until ack is sampled, then releases
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00);
    check(nm, q, e);
  endtask

  task automatic run(input int n, input tcoc_cs_e cs);
    wr(`TCOC_OFF_CTRL_B, {5'h00, cs});
    repeat (n) @(posedge clk);
    wr(`TCOC_OFF_CTRL_B, 8'h00);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 7; i++) rd(5'(i * 4), 8'h00, "reset value");
    rd(`TCOC_OFF_STATUS, 8'h08, "status bottom");
    wr(`TCOC_OFF_COUNT, 8'hFF);
    repeat (20) @(posedge clk);
    rd(`TCOC_OFF_COUNT, 8'hFF, "stopped count");
    rd(`TCOC_OFF_STATUS, 8'h10, "status max");
  endtask

  task automatic t_normal;
    wr(`TCOC_OFF_MASK, 8'h01);
    wr(`TCOC_OFF_COUNT, 8'hFD);
    run(12, TCOC_CS_DIV1);
    rd(`TCOC_OFF_FLAGS, 8'h07, "wrap flags");
    check("irq ovf only", {5'h00, irq}, 8'h01);
    wr(`TCOC_OFF_FLAGS, 8'h07);
    rd(`TCOC_OFF_FLAGS, 8'h00, "flags cleared");
  endtask

  task automatic t_block;
    wr(`TCOC_OFF_CMP_A, 8'h40);
    wr(`TCOC_OFF_CMP_B, 8'h40);
    wr(`TCOC_OFF_COUNT, 8'h40);
    run(20, TCOC_CS_DIV1);
    rd(`TCOC_OFF_FLAGS, 8'h00, "blocked match");
    wr(`TCOC_OFF_COUNT, 8'h3E);
    run(20, TCOC_CS_DIV1);
    rd(`TCOC_OFF_FLAGS, 8'h06, "match flags");
  endtask

  task automatic t_ctc;
    wr(`TCOC_OFF_FLAGS, 8'h07);
    wr(`TCOC_OFF_CTRL_A, 8'h02);
    wr(`TCOC_OFF_CMP_A, 8'h05);
    wr(`TCOC_OFF_COUNT, 8'h00);
    run(300, TCOC_CS_DIV1);
    acc(1'b0, `TCOC_OFF_COUNT, 8'h00);
    check("ctc bound", {7'h00, q <= 8'h05}, 8'h01);
    rd(`TCOC_OFF_FLAGS, 8'h02, "ctc flags");
  endtask

  task automatic t_force;
    wr(`TCOC_OFF_CTRL_A, 8'h70);
    wr(`TCOC_OFF_FLAGS, 8'h07);
    wr(`TCOC_OFF_CTRL_B, 8'hC0);
    repeat (3) @(posedge clk);
    check("forced out", oa, 8'h01);
    check("forced out b", ob, 8'h01);
    check("out enable", oa_en, 8'h01);
    check("out enable b", ob_en, 8'h01);
    rd(`TCOC_OFF_FLAGS, 8'h00, "force flags");
  endtask

  // Active compare A still 0x05 while the new value waits in the buffer
  task automatic t_buffer;
    wr(`TCOC_OFF_CTRL_A, 8'h03);
    wr(`TCOC_OFF_CMP_A, 8'h22);
    rd(`TCOC_OFF_CMP_A, 8'h22, "buffer read");
    wr(`TCOC_OFF_COUNT, 8'h20);
    run(10, TCOC_CS_DIV1);
    rd(`TCOC_OFF_FLAGS, 8'h00, "buffer held");
    wr(`TCOC_OFF_COUNT, 8'hF0);
    run(70, TCOC_CS_DIV1);
    rd(`TCOC_OFF_FLAGS, 8'h03, "buffer loaded");
  endtask

  task automatic t_service;
    wr(`TCOC_OFF_MASK, 8'h02);
    repeat (3) @(posedge clk);
    check("irq a", {5'h00, irq}, 8'h02);
    svc <= 3'b010;
    @(posedge clk);
    svc <= 3'b000;
    repeat (3) @(posedge clk);
    check("irq serviced", {5'h00, irq}, 8'h00);
    rd(`TCOC_OFF_FLAGS, 8'h01, "serviced flags");
    wr(`TCOC_OFF_MASK, 8'h00);
  endtask

  // Phase-correct turns at 0xFF and counts down; overflow comes at the bottom turn
  task automatic t_phase;
    wr(`TCOC_OFF_FLAGS, 8'h07);
    wr(`TCOC_OFF_CTRL_A, 8'h01);
    wr(`TCOC_OFF_COUNT, 8'hFE);
    run(4, TCOC_CS_DIV1);
    rd(`TCOC_OFF_COUNT, 8'hF9, "phase down count");
    rd(`TCOC_OFF_STATUS, 8'h07, "phase status");
    rd(`TCOC_OFF_FLAGS, 8'h00, "phase top flags");
    wr(`TCOC_OFF_COUNT, 8'h03);
    run(4, TCOC_CS_DIV1);
    rd(`TCOC_OFF_COUNT, 8'h04, "phase up count");
    rd(`TCOC_OFF_FLAGS, 8'h01, "phase bottom flags");
  endtask

  // Mode 7 wraps at compare A; A toggles there, inverted B clears at BOTTOM
  task automatic t_fast7;
    wr(`TCOC_OFF_CTRL_A, 8'h73);
    wr(`TCOC_OFF_CTRL_B, 8'h08);
    wr(`TCOC_OFF_FLAGS, 8'h07);
    wr(`TCOC_OFF_COUNT, 8'h1E);
    wr(`TCOC_OFF_CTRL_B, 8'h09);
    repeat (4) @(posedge clk);
    wr(`TCOC_OFF_CTRL_B, 8'h08);
    rd(`TCOC_OFF_COUNT, 8'h02, "top at compare a");
    rd(`TCOC_OFF_FLAGS, 8'h03, "fast7 flags");
    check("toggle at top", oa, 8'h00);
    check("clear at bottom", ob, 8'h00);
  endtask

  task automatic t_sources;
    wr(`TCOC_OFF_CTRL_A, 8'h00);
    for (int e = 6; e < 8; e++) begin
      wr(`TCOC_OFF_COUNT, 8'h00);
      wr(`TCOC_OFF_CTRL_B, 8'(e));
      repeat (3) begin
        pin <= 1'b1;
        repeat (4) @(posedge clk);
        pin <= 1'b0;
        repeat (4) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      wr(`TCOC_OFF_CTRL_B, 8'h00);
      rd(`TCOC_OFF_COUNT, 8'h03, "pin edges");
    end
    for (int cs = 1; cs < 6; cs++) begin
      wr(`TCOC_OFF_COUNT, 8'h00);
      run(1030, tcoc_cs_e'(cs));
      acc(1'b0, `TCOC_OFF_COUNT, 8'h00);
      check("prescaled count", {7'h00, q != 8'h00}, 8'h01);
      if (cs == 1) check("undivided count", q, 8'h09);
    end
  endtask

  // Reset in mid-run must return both output states to zero
  task automatic t_reset2;
    wr(`TCOC_OFF_CTRL_A, 8'hF0);
    wr(`TCOC_OFF_CTRL_B, 8'hC0);
    repeat (3) @(posedge clk);
    check("set by force a", oa, 8'h01);
    check("set by force b", ob, 8'h01);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    check("reset out a", oa, 8'h00);
    check("reset out b", ob, 8'h00);
    rd(`TCOC_OFF_STATUS, 8'h08, "reset status");
    rd(`TCOC_OFF_CTRL_A, 8'h00, "reset control a");
  endtask

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'h1;
    dat_i = 32'h0000_0000;
    pin = 1'b0;
    svc = 3'b000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_normal;
    t_block;
    t_ctc;
    t_force;
    t_buffer;
    t_service;
    t_phase;
    t_fast7;
    t_sources;
    t_reset2;
    wrap_up;
  end

  // Whole run is near 6000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    wrap_up;
  end
endmodule // tb_tcoc_top

bind tcoc_top tcoc_checker u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ_REQ(IRQ_REQ),
  .COMPARE_OUTPUT_A(COMPARE_OUTPUT_A), .COMPARE_OUTPUT_B(COMPARE_OUTPUT_B),
  .COMPARE_OUTPUT_A_EN(COMPARE_OUTPUT_A_EN), .COMPARE_OUTPUT_B_EN(COMPARE_OUTPUT_B_EN));

`default_nettype wire
